// file: rtl/bidir_fifo_pkg.sv
// constants and carrier types for the bidirectional fifo port block
package bidir_fifo_pkg;
   localparam int DATA_W = 36;
   localparam int OFS_W = 10;
   localparam int FIFO_DEPTH = 8;
   localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
   localparam int SYNC_STAGES = 2;
   localparam logic [OFS_W:0] DEPTH_EXT = 11'h008;
   localparam logic [OFS_W-1:0] PRESET_BOTH = 10'h040;
   localparam logic [OFS_W-1:0] PRESET_HIGH = 10'h010;
   localparam logic [OFS_W-1:0] PRESET_LOW = 10'h008;
   localparam logic [OFS_W-1:0] OFS_RESET = 10'h040;
   // programming step order
   localparam logic [1:0] STEP_FWD_AF = 2'h0;
   localparam logic [1:0] STEP_FWD_AE = 2'h1;
   localparam logic [1:0] STEP_REV_AF = 2'h2;
   localparam logic [1:0] STEP_REV_AE = 2'h3;

   // one port's control pins; rw_pin is the raw write/read select level
   typedef struct packed {
      logic select_n;
      logic rw_pin;
      logic enable;
      logic mailbox_sel;
   } port_ctl_s;

   typedef struct packed {
      logic space_flag;
      logic data_flag;
      logic almost_empty_n;
      logic almost_full_n;
   } port_flags_s;
endpackage

// file: rtl/bidir_fifo_port_and_offset_prog.sv
// bidirectional fifo pair with port decode, offset programming and flags
// Functional notes
// - selects sampled at a fifo reset rising edge pick preset offsets
// - selects high/high give 64, high/low 16, low/high 8, to both offsets
// - forward offsets follow forward reset, reverse offsets reverse reset
// - first four port A fifo writes load fwd af, fwd ae, rev af, rev ae
// - offsets come from the low port A data bits, msb highest
// - after fourth offset write port B space flag rises, normal operation
// - port A bus drives only with select low and write/read low
// - port A qualified write with space flag pushes into forward fifo
// - port A qualified read with data flag pops reverse fifo
// - port B bus drives only with select low and read/write high
// - port B qualified write with space flag pushes into reverse fifo
// - port B qualified read with data flag pops forward fifo
// - each port transfers independently of the other port
// - enable low on a port edge means no transfer
// - fall-through mode: word shifts out on edge raising data flag
// - fall-through with data flag high: advance only on qualified read
// - standard mode: data flag rises on second read edge, read needed
// - every port flag passes two stages clocked by its own port edges
// - mailbox write stores word, mailbox read sets full flag high
// - space flag low: writes to that fifo ignored
// - data flag low: reads ignored, output word held except for the fall-through shift
// - almost-empty on read port, almost-full on write port
`timescale 1ns/1ps

module fifo_buffer #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 8
) (
   input wire logic i_clk,
   input wire logic i_clear,
   input wire logic i_wr_valid,
   output logic o_wr_ready,
   input wire logic [WIDTH-1:0] i_wr_data,
   output logic o_rd_valid,
   input wire logic i_rd_ready,
   output logic [WIDTH-1:0] o_rd_data,
   output logic [$clog2(DEPTH+1)-1:0] o_count
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [CW-1:0] count;
   wire do_wr = i_wr_valid & o_wr_ready;
   wire do_rd = i_rd_ready & o_rd_valid;

   assign o_wr_ready = (count != CW'(DEPTH));
   assign o_rd_valid = (count != '0);
   assign o_rd_data = mem[rd_ptr];
   assign o_count = count;

   always_ff @(posedge i_clk) begin
      if (do_wr) begin
         mem[wr_ptr] <= i_wr_data;
      end
   end

   // pointers and fill count, cleared together
   always_ff @(posedge i_clk) begin
      if (i_clear) begin
         wr_ptr <= '0;
      end else begin
         wr_ptr <= wr_ptr + AW'(do_wr);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_clear) begin
         rd_ptr <= '0;
      end else begin
         rd_ptr <= rd_ptr + AW'(do_rd);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_clear) begin
         count <= '0;
      end else begin
         count <= count + CW'(do_wr) - CW'(do_rd);
      end
   end
endmodule // fifo_buffer

module bidir_fifo_port_and_offset_prog
   import bidir_fifo_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_port_a_clock,
   input wire logic i_port_b_clock,
   input wire port_ctl_s i_port_a_ctl,
   input wire port_ctl_s i_port_b_ctl,
   input wire logic [DATA_W-1:0] i_port_a_bus,
   input wire logic [DATA_W-1:0] i_port_b_bus,
   output logic [DATA_W-1:0] o_port_a_bus,
   output logic [DATA_W-1:0] o_port_b_bus,
   output logic o_port_a_bus_oe,
   output logic o_port_b_bus_oe,
   input wire logic i_fwd_fifo_reset_n,
   input wire logic i_rev_fifo_reset_n,
   input wire logic i_offset_select_low,
   input wire logic i_offset_select_high,
   input wire logic i_fall_through_select,
   output port_flags_s o_port_a_flags,
   output port_flags_s o_port_b_flags,
   output logic o_fwd_mailbox_full_n,
   output logic o_rev_mailbox_full_n
);
   // index 0: port A / forward fifo, index 1: port B / reverse fifo
   logic [1:0] clk_q;
   logic [1:0] rst_q;
   logic prog;
   logic [1:0] step;
   logic [OFS_W-1:0] ae_ofs [2];
   logic [OFS_W-1:0] af_ofs [2];
   logic [DATA_W-1:0] out_data [2];
   logic [DATA_W-1:0] mbox [2];
   logic [DATA_W-1:0] obus [2];
   logic [1:0] ooe;
   logic [1:0] mb_full_n;
   logic [1:0] data_flag;
   logic [SYNC_STAGES-1:0] space_s [2];
   logic [SYNC_STAGES-1:0] ae_s [2];
   logic [SYNC_STAGES-1:0] af_s [2];
   logic [1:0] is_wr;
   logic [1:0] qual;
   logic [1:0] fifo_wr;
   logic [1:0] fifo_rd;
   logic [1:0] mb_wr;
   logic [1:0] mb_rd;
   port_ctl_s ctl [2];
   logic [DATA_W-1:0] bus_in [2];

   wire [1:0] port_clk = {i_port_b_clock, i_port_a_clock};
   wire [1:0] fifo_rst_n = {i_rev_fifo_reset_n, i_fwd_fifo_reset_n};
   wire [1:0] port_edge = port_clk & ~clk_q;
   wire [1:0] rst_rise = fifo_rst_n & ~rst_q;
   wire [1:0] fifo_clr = ~fifo_rst_n | {2{~i_resetn}};
   wire sel_any = i_offset_select_high | i_offset_select_low;
   wire prog_enter = rst_rise[0] & ~sel_any;
   // programming already counts in the release cycle, before prog is set
   wire prog_now = prog | prog_enter;
   wire prog_wr = prog & fifo_wr[0] & space_s[0][SYNC_STAGES-1];
   wire prog_done = prog_wr & (step == STEP_REV_AE);
   wire [OFS_W-1:0] prog_val = i_port_a_bus[OFS_W-1:0];
   wire [OFS_W-1:0] preset_val =
      (i_offset_select_high & i_offset_select_low) ? PRESET_BOTH :
      i_offset_select_high ? PRESET_HIGH : PRESET_LOW;

   assign ctl[0] = i_port_a_ctl;
   assign ctl[1] = i_port_b_ctl;
   assign bus_in[0] = i_port_a_bus;
   assign bus_in[1] = i_port_b_bus;

   // clock history follows the pin in reset too: no false edge after it
   always_ff @(posedge i_mclk) begin
      clk_q <= port_clk;
   end

   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         rst_q <= 2'h3;
      end else begin
         rst_q <= fifo_rst_n;
      end
   end

   // programming mode flag
   always_ff @(posedge i_mclk) begin
      if (!i_resetn) begin
         prog <= 1'b0;
      end else if (prog_enter) begin
         prog <= 1'b1;
      end else if (prog_done) begin
         prog <= 1'b0;
      end
   end

   // programming step counter
   always_ff @(posedge i_mclk) begin
      if (|fifo_clr) begin
         step <= STEP_FWD_AF;
      end else if (prog_wr) begin
         step <= step + 2'h1;
      end
   end

   genvar p;
   generate
      for (p = 0; p < 2; p++) begin : g_port
         localparam int R = 1 - p;
         logic f_ready;
         logic f_valid;
         logic [DATA_W-1:0] f_data;
         logic [CNT_W-1:0] f_count;
         logic [SYNC_STAGES-1:0] avail;
         logic fall_through_select;
         logic fall_through_select_pend;

         // port decode; port B's write/read pin has inverted sense
         assign is_wr[p] = ctl[p].rw_pin ^ (p == 1);
         assign qual[p] = port_edge[p] & ~ctl[p].select_n
            & ctl[p].enable;
         assign fifo_wr[p] = qual[p] & is_wr[p] & ~ctl[p].mailbox_sel;
         assign fifo_rd[p] = qual[p] & ~is_wr[p] & ~ctl[p].mailbox_sel;
         assign mb_wr[p] = qual[p] & is_wr[p] & ctl[p].mailbox_sel;
         assign mb_rd[p] = qual[p] & ~is_wr[p] & ctl[p].mailbox_sel;

         // fifo p is written at port p and read at port R
         wire wr_ok = fifo_wr[p] & space_s[p][SYNC_STAGES-1];
         wire push = wr_ok & f_ready
            & ~(prog_now & (p == 0));
         wire rd_req = fifo_rd[R] & data_flag[p];
         wire fall = port_edge[R] & avail[SYNC_STAGES-1] & f_valid
            & (~data_flag[p] | rd_req);
         wire pop = fall_through_select ? fall : (rd_req & f_valid);
         wire [OFS_W-1:0] cnt_ext = OFS_W'(f_count);
         wire space_raw = f_ready & ~(prog_now & (p == 1));
         wire ae_raw_n = cnt_ext > ae_ofs[p];
         wire af_raw_n = ({1'b0, cnt_ext} + {1'b0, af_ofs[p]})
            < DEPTH_EXT;
         wire left = f_count > CNT_W'(pop);

         fifo_buffer #(
            .WIDTH(DATA_W),
            .DEPTH(FIFO_DEPTH)
         ) u_fifo (
            .i_clk(i_mclk),
            .i_clear(fifo_clr[p]),
            .i_wr_valid(push),
            .o_wr_ready(f_ready),
            .i_wr_data(bus_in[p]),
            .o_rd_valid(f_valid),
            .i_rd_ready(pop),
            .o_rd_data(f_data),
            .o_count(f_count)
         );

         // mode pin caught at first writer edge after reset release
         always_ff @(posedge i_mclk) begin
            if (fifo_clr[p]) begin
               fall_through_select_pend <= 1'b1;
               fall_through_select <= 1'b0;
            end else if (fall_through_select_pend & port_edge[p]) begin
               fall_through_select_pend <= 1'b0;
               fall_through_select <= ~i_fall_through_select;
            end
         end

         // offsets of fifo p: preset at its reset release or loaded from A
         wire preset_ld = rst_rise[p] & sel_any;
         wire [1:0] af_step = (p == 0) ? STEP_FWD_AF : STEP_REV_AF;
         wire [1:0] ae_step = (p == 0) ? STEP_FWD_AE : STEP_REV_AE;
         wire af_ld = prog_wr & (step == af_step);
         wire ae_ld = prog_wr & (step == ae_step);
         wire next_data_flag = fall_through_select
            ? (fall | (data_flag[p] & ~rd_req))
            : (avail[SYNC_STAGES-2] & left);
         wire [DATA_W-1:0] next_obus = ctl[p].mailbox_sel ? mbox[R]
            : out_data[R];

         always_ff @(posedge i_mclk) begin
            if (!i_resetn) begin
               ae_ofs[p] <= OFS_RESET;
               af_ofs[p] <= OFS_RESET;
            end else if (preset_ld) begin
               ae_ofs[p] <= preset_val;
               af_ofs[p] <= preset_val;
            end else begin
               if (af_ld) begin
                  af_ofs[p] <= prog_val;
               end
               if (ae_ld) begin
                  ae_ofs[p] <= prog_val;
               end
            end
         end

         // read side: staged availability and almost-empty
         always_ff @(posedge i_mclk) begin
            if (fifo_clr[p]) begin
               avail <= '0;
               ae_s[p] <= '0;
            end else if (port_edge[R]) begin
               avail <= {avail[SYNC_STAGES-2:0], f_valid};
               ae_s[p] <= {ae_s[p][SYNC_STAGES-2:0], ae_raw_n};
            end
         end

         // output register keeps its word unless popped
         always_ff @(posedge i_mclk) begin
            if (fifo_clr[p]) begin
               out_data[p] <= '0;
            end else if (pop) begin
               out_data[p] <= f_data;
            end
         end

         // data flag: fall-through shift or standard two-edge rise
         always_ff @(posedge i_mclk) begin
            if (fifo_clr[p]) begin
               data_flag[p] <= 1'b0;
            end else if (port_edge[R]) begin
               data_flag[p] <= next_data_flag;
            end
         end

         // write side flags
         always_ff @(posedge i_mclk) begin
            if (fifo_clr[p]) begin
               space_s[p] <= '0;
               af_s[p] <= '1;
            end else if (port_edge[p]) begin
               space_s[p] <= {space_s[p][SYNC_STAGES-2:0], space_raw};
               af_s[p] <= {af_s[p][SYNC_STAGES-2:0], af_raw_n};
            end
         end

         // mailbox p: written at port p, read at port R; write wins
         always_ff @(posedge i_mclk) begin
            if (fifo_clr[p]) begin
               mb_full_n[p] <= 1'b1;
               mbox[p] <= '0;
            end else if (mb_wr[p]) begin
               mbox[p] <= bus_in[p];
               mb_full_n[p] <= 1'b0;
            end else if (mb_rd[R]) begin
               mb_full_n[p] <= 1'b1;
            end
         end

         // port p data pins show fifo R or mailbox R
         always_ff @(posedge i_mclk) begin
            if (!i_resetn) begin
               obus[p] <= '0;
            end else begin
               obus[p] <= next_obus;
            end
         end

         // pin drive enable tracks select and read sense
         always_ff @(posedge i_mclk) begin
            if (!i_resetn) begin
               ooe[p] <= 1'b0;
            end else begin
               ooe[p] <= ~ctl[p].select_n & ~is_wr[p];
            end
         end
      end
   endgenerate

   assign o_port_a_bus = obus[0];
   assign o_port_b_bus = obus[1];
   assign o_port_a_bus_oe = ooe[0];
   assign o_port_b_bus_oe = ooe[1];
   assign o_port_a_flags.space_flag = space_s[0][SYNC_STAGES-1];
   assign o_port_a_flags.data_flag = data_flag[1];
   assign o_port_a_flags.almost_empty_n = ae_s[1][SYNC_STAGES-1];
   assign o_port_a_flags.almost_full_n = af_s[0][SYNC_STAGES-1];
   assign o_port_b_flags.space_flag = space_s[1][SYNC_STAGES-1];
   assign o_port_b_flags.data_flag = data_flag[0];
   assign o_port_b_flags.almost_empty_n = ae_s[0][SYNC_STAGES-1];
   assign o_port_b_flags.almost_full_n = af_s[1][SYNC_STAGES-1];
   assign o_fwd_mailbox_full_n = mb_full_n[0];
   assign o_rev_mailbox_full_n = mb_full_n[1];
endmodule // bidir_fifo_port_and_offset_prog

// file: tb/bidir_fifo_checker.sv
// port-level assertions for the bidirectional fifo block
`timescale 1ns/1ps
module fifo_chk
   import bidir_fifo_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic i_port_a_clock,
   input wire logic i_port_b_clock,
   input wire port_ctl_s i_port_a_ctl,
   input wire port_ctl_s i_port_b_ctl,
   input wire logic o_port_a_bus_oe,
   input wire logic o_port_b_bus_oe,
   input wire logic i_fwd_fifo_reset_n,
   input wire logic i_rev_fifo_reset_n,
   input wire logic i_offset_select_low,
   input wire logic i_offset_select_high,
   input wire port_flags_s o_port_a_flags,
   input wire port_flags_s o_port_b_flags,
   input wire logic o_fwd_mailbox_full_n
);
   logic a_q;
   logic b_q;
   always_ff @(posedge i_mclk) begin
      a_q <= i_port_a_clock;
      b_q <= i_port_b_clock;
   end
   wire a_edge = i_port_a_clock && !a_q;
   wire b_edge = i_port_b_clock && !b_q;
   wire rst_ok = i_fwd_fifo_reset_n && i_rev_fifo_reset_n;
   wire a_mail = a_edge && i_port_a_ctl == 4'b0111;
   wire b_mail = b_edge && i_port_b_ctl == 4'b0111;
   wire a_drv = !i_port_a_ctl.select_n && !i_port_a_ctl.rw_pin;
   wire b_drv = !i_port_b_ctl.select_n && i_port_b_ctl.rw_pin;
   wire prog = !i_offset_select_low && !i_offset_select_high;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);
   a_drive_a: assert property ($past(i_resetn) |->
      o_port_a_bus_oe == $past(a_drv)) else $error("port a enable");
   b_drive_a: assert property ($past(i_resetn) |->
      o_port_b_bus_oe == $past(b_drv)) else $error("port b enable");
   fwd_clear_a: assert property (!i_fwd_fifo_reset_n |=>
      !o_port_a_flags.space_flag && o_port_a_flags.almost_full_n &&
      !o_port_b_flags.almost_empty_n && o_fwd_mailbox_full_n)
      else $error("fwd reset flags");
   rev_clear_a: assert property (!i_rev_fifo_reset_n |=>
      !o_port_a_flags.data_flag && !o_port_a_flags.almost_empty_n &&
      o_port_b_flags.almost_full_n) else $error("rev reset flags");
   mail_set_a: assert property (a_mail && i_fwd_fifo_reset_n |=>
      !o_fwd_mailbox_full_n) else $error("mail write");
   mail_take_a: assert property (b_mail && !a_mail &&
      i_fwd_fifo_reset_n |=> o_fwd_mailbox_full_n) else $error("mail read");
   a_flags_a: assert property (!a_edge && rst_ok |=>
      $stable(o_port_a_flags)) else $error("port a flag timing");
   b_flags_a: assert property (!b_edge && rst_ok |=>
      $stable(o_port_b_flags)) else $error("port b flag timing");
   prog_hold_a: assert property ($rose(i_fwd_fifo_reset_n) && prog
      |=> !o_port_b_flags.space_flag [*4]) else $error("space during prog");
   mail_cov: cover property (a_mail);
   prog_cov: cover property ($rose(i_fwd_fifo_reset_n) && prog);
   data_cov: cover property ($rose(o_port_b_flags.data_flag));
endmodule // fifo_chk
bind bidir_fifo_port_and_offset_prog fifo_chk u_chk (
   .i_mclk(i_mclk), .i_resetn(i_resetn),
   .i_port_a_clock(i_port_a_clock), .i_port_b_clock(i_port_b_clock),
   .i_port_a_ctl(i_port_a_ctl), .i_port_b_ctl(i_port_b_ctl),
   .o_port_a_bus_oe(o_port_a_bus_oe), .o_port_b_bus_oe(o_port_b_bus_oe),
   .i_fwd_fifo_reset_n(i_fwd_fifo_reset_n),
   .i_rev_fifo_reset_n(i_rev_fifo_reset_n),
   .i_offset_select_low(i_offset_select_low),
   .i_offset_select_high(i_offset_select_high),
   .o_port_a_flags(o_port_a_flags), .o_port_b_flags(o_port_b_flags),
   .o_fwd_mailbox_full_n(o_fwd_mailbox_full_n));

// file: tb/port_b_host.sv
// port b host: free-running port clock, reads, word capture
`timescale 1ns/1ps
module port_b_host
   import bidir_fifo_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_go,
   input wire logic i_mb,
   input wire logic i_wr,
   input wire port_flags_s i_flags,
   input wire logic [DATA_W-1:0] i_bus,
   output logic o_clock,
   output port_ctl_s o_ctl,
   output logic [DATA_W-1:0] o_drive,
   output logic o_got,
   output logic [DATA_W-1:0] o_word
);
   logic [1:0] cnt = 2'h0;
   logic [1:0] taken = 2'h0;
   assign o_clock = cnt[1];
   assign o_ctl = {1'b0, ~i_wr, i_go, i_mb};
   // bus driven by us: toggling pattern
   assign o_drive = {18{cnt[0], ~cnt[0]}};
   always @(posedge i_mclk) begin
      cnt <= #1 cnt + 2'h1;
      taken <= {taken[0], cnt == 2'h2 && i_go && (i_mb ||
         (i_wr ? i_flags.space_flag : i_flags.data_flag))};
      o_got <= taken[1];
      o_word <= i_bus;
   end
endmodule // port_b_host

// file: tb/bidir_fifo_port_and_offset_prog_tb.sv
// testbench for the bidirectional fifo port block
`timescale 1ns/1ps
module bidir_fifo_port_and_offset_prog_tb;
   import bidir_fifo_pkg::*;
   logic i_mclk = 1'b0;
   logic i_resetn = 1'b0;
   logic a_clk = 1'b0;
   logic rst_n = 1'b0;
   logic sel_lo = 1'b0;
   logic sel_hi = 1'b0;
   logic go = 1'b0;
   logic mb = 1'b0;
   logic wr = 1'b0;
   logic fts = 1'b1;
   logic rmbf;
   logic [DATA_W-1:0] a_bus;
   port_ctl_s a_ctl = '0;
   port_ctl_s b_ctl;
   logic [DATA_W-1:0] a_dat = '0;
   logic [DATA_W-1:0] b_in, b_bus, word;
   logic b_clk, a_oe, b_oe, mbf, got;
   port_flags_s a_fl, b_fl;
   int n_mismatch = 0;
   int n_compared = 0;
   int ofs[4];
   int pre[4] = '{0, 8, 16, 64};
   logic [DATA_W-1:0] q[$];
   logic [DATA_W-1:0] d;
   bidir_fifo_port_and_offset_prog uut (.i_mclk(i_mclk),
      .i_resetn(i_resetn), .i_port_a_clock(a_clk), .i_port_b_clock(b_clk),
      .i_port_a_ctl(a_ctl), .i_port_b_ctl(b_ctl), .i_port_a_bus(a_dat),
      .i_port_b_bus(b_in), .o_port_a_bus(a_bus), .o_port_b_bus(b_bus),
      .o_port_a_bus_oe(a_oe), .o_port_b_bus_oe(b_oe),
      .i_fwd_fifo_reset_n(rst_n), .i_rev_fifo_reset_n(rst_n),
      .i_offset_select_low(sel_lo), .i_offset_select_high(sel_hi),
      .i_fall_through_select(fts),
      .o_port_a_flags(a_fl), .o_port_b_flags(b_fl),
      .o_fwd_mailbox_full_n(mbf), .o_rev_mailbox_full_n(rmbf));
   port_b_host host (.i_mclk(i_mclk), .i_go(go), .i_mb(mb), .i_wr(wr),
      .i_flags(b_fl),
      .i_bus(b_bus), .o_clock(b_clk), .o_ctl(b_ctl), .o_drive(b_in),
      .o_got(got), .o_word(word));
   always #5 i_mclk = ~i_mclk;
   function automatic logic [2:0] expect_fl(int c, int x, int y);
      return {c < FIFO_DEPTH, c + y < FIFO_DEPTH, c > x};
   endfunction
   task automatic chk(input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] e);
      n_compared++;
      if (s !== e) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic aop(input port_ctl_s c, input logic [DATA_W-1:0] v);
      @(posedge i_mclk);
      #1 a_ctl = c;
      a_dat = v;
      a_clk = 1'b0;
      repeat (2) @(posedge i_mclk);
      #1 a_clk = 1'b1;
      repeat (2) @(posedge i_mclk);
   endtask
   task automatic idle();
      aop({1'($urandom), 1'($urandom), 1'b0, 1'($urandom)},
         DATA_W'({$urandom, $urandom}));
   endtask
   task automatic wait_got();
      @(posedge i_mclk);
      for (int t = 0; t < 60 && got !== 1'b1; t++) @(posedge i_mclk);
      chk(got, 1'b1);
   endtask
   task automatic fill(input int x, input int y);
      int c;
      repeat (2) idle();
      for (int k = 1; k <= FIFO_DEPTH + 1; k++) begin
         d = DATA_W'({$urandom, $urandom});
         aop(4'b0110, d);
         if (k <= FIFO_DEPTH || !fts) q.push_back(d);
         repeat (5) idle();
         c = fts ? (k > FIFO_DEPTH ? FIFO_DEPTH : k) : k - 1;
         chk({a_fl.space_flag, a_fl.almost_full_n, b_fl.almost_empty_n},
            expect_fl(c, x, y));
      end
      if (!fts) chk(b_bus, q.pop_front());
      @(posedge i_mclk);
      #1 go = 1'b1;
      while (q.size() > 0) begin
         wait_got();
         chk(word, q.pop_front());
      end
      if (!fts) wait_got();
      #1 go = 1'b0;
      repeat (8) @(posedge i_mclk);
      chk(b_fl.data_flag, 1'b0);
   endtask
   task automatic conclude();
      $display("mismatches %0d compared %0d", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #200000;
      n_mismatch++;
      conclude();
   end
   initial begin
      void'($urandom(46));
      repeat (10) @(posedge i_mclk);
      #1 i_resetn = 1'b1;
      for (int i = 0; i < 4; i++) begin
         aop({i[1], i[0], 2'b00}, '0);
         chk(a_oe, i == 0);
         chk(b_oe, 1'b1);
      end
      #1 rst_n = 1'b1;
      repeat (2) idle();
      for (int i = 0; i < 4; i++) begin
         ofs[i] = $urandom_range(1, 4);
         aop(4'b0110, {26'($urandom), 10'(ofs[i])});
         if (i < 3) chk(b_fl.space_flag, 1'b0);
      end
      repeat (12) @(posedge i_mclk);
      chk(b_fl.space_flag, 1'b1);
      fill(ofs[1], ofs[0]);
      d = DATA_W'({$urandom, $urandom});
      aop(4'b0111, d);
      chk(mbf, 1'b0);
      #1 mb = 1'b1;
      go = 1'b1;
      wait_got();
      chk(word, d);
      #1 go = 1'b0;
      mb = 1'b0;
      chk(mbf, 1'b1);
      #1 wr = 1'b1;
      go = 1'b1;
      wait_got();
      #1 go = 1'b0;
      wr = 1'b0;
      repeat (3) idle();
      aop(4'b0010, '0);
      @(posedge i_mclk);
      chk(a_bus, {18{2'b01}});
      chk(rmbf, 1'b1);
      for (int i = 1; i < 4; i++) begin
         #1 rst_n = 1'b0;
         fts = ~i[0];
         sel_lo = i[0];
         sel_hi = i[1];
         repeat (8) @(posedge i_mclk);
         #1 rst_n = 1'b1;
         repeat (2) @(posedge i_mclk);
         fill(pre[i], pre[i]);
      end
      conclude();
   end
endmodule // bidir_fifo_port_and_offset_prog_tb
